// *** hw/dlem_pkg.sv ***
// Constants and types shared by the link error monitor
package dlem_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LINK_CTRL    = 8'h04;
    localparam logic [7:0] ADDR_FILTER_CTRL  = 8'h05;
    localparam logic [7:0] ADDR_GPIO_CTRL    = 8'h06;
    localparam logic [7:0] ADDR_LOCK_CTRL    = 8'h07;
    localparam logic [7:0] ADDR_CRYPT_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_DECODE_ERR   = 8'h0D;
    localparam logic [7:0] ADDR_PATTERN_ERR  = 8'h0E;
    localparam logic [7:0] ADDR_ERR_THRESH   = 8'h0F;
    localparam logic [7:0] ADDR_LOCK_LAST    = 8'h1F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_REV_CC      = 0;
    localparam int BIT_FWD_CC      = 1;
    localparam int BIT_PATTERN_EN  = 5;
    localparam int BIT_GPIO0_IN    = 0;
    localparam int BIT_GPIO0_OUT   = 1;
    localparam int BIT_GPIO1_IN    = 2;
    localparam int BIT_GPIO1_OUT   = 3;
    localparam int BIT_AUTO_CLEAR  = 5;
    localparam int BIT_GPIO0_SEL   = 1;
    localparam int BIT_GPIO1_SEL   = 2;
    localparam int BIT_CFG_LOCK    = 0;
    localparam int BIT_CRYPT_EN    = 0;
    localparam int BIT_AUTH_BEGUN  = 1;

    // ------------------------------------------------------------
    // Reset values and counter limit
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LINK_CTRL   = 8'h03;
    localparam logic [7:0] RST_GPIO_CTRL   = 8'h0A;
    localparam logic [7:0] RST_ERR_THRESH  = 8'h00;
    localparam logic [7:0] COUNT_MAX       = 8'hFF;

    // ------------------------------------------------------------
    // Error rate window: 16 symbols, loss at 4 errors (1 in 4)
    // ------------------------------------------------------------
    localparam logic [3:0] WIN_LAST        = 4'hF;
    localparam logic [2:0] WIN_LOSS_ERRS   = 3'h4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;
    localparam int AUTO_CLEAR_NS     = 1000;
    localparam int AUTO_CLEAR_CYC    = AUTO_CLEAR_NS / CLK_PERIOD_NS;
    localparam int REV_BLACKOUT_US   = 500;
    localparam int REV_BLACKOUT_CYC  = (REV_BLACKOUT_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        DLEM_UNLOCKED = 2'b00,
        DLEM_LOCKED   = 2'b01,
        DLEM_RELOCK   = 2'b10
    } dlem_lock_e;

endpackage : dlem_pkg

// *** hw/dlem_monitor.sv ***
// Link error monitor, self test and control-channel supervision
//
// Operation
// - Decoding errors counted in 8-bit readable counter at 0x0D.
// - Error rate of 1/4 or more drops lock, freezes counter, relock.
// - Counter cleared by video lock, register read, or auto clear.
// - Pattern test errors go to own register; decode counter held zero.
// - Error pin low above threshold, or on any pattern error in test.
// - Error pin released when the decode counter is cleared, unless 0x0E is nonzero in pattern test.
// - Auto clear releases the pin and counter 1 us after assertion.
// - Auto clear off at reset; enabled by bit 5 of 0x06.
// - Auto clear never runs during pattern test.
// - Forward and reverse channel enables at 0x04 bits 1 and 0.
// - No acknowledge frame for a transfer lost to contention.
// - Lock bit makes 0x00 to 0x1F read-only until reset.
// - Key vector write sets auth flag; GPIO1 follows if selected.
// - GPIO0 follows encryption enable when selected.
// - Reverse channel unavailable 500 us after link start or stop.
// - Lock output only for video link, never in configuration link.
`timescale 1ns/1ns
`default_nettype none

module dlem_monitor
    import dlem_pkg::*;
#(
    parameter int REV_BLACKOUT_CYCLES = REV_BLACKOUT_CYC
) (
    // Clock, reset, enable
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // Register port
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_rvalid_o,
    // Serial decoder events
    input  wire logic       symbol_valid_i,
    input  wire logic       decode_err_i,
    input  wire logic       pattern_err_i,
    input  wire logic       video_lock_acq_i,
    input  wire logic       config_link_i,
    input  wire logic       link_start_stop_i,
    input  wire logic       key_vector_written_i,
    output logic            lock_o,
    output logic            relock_req_o,
    output logic            pattern_test_active_o,
    output logic      [2:0] filter_bypass_o,
    // Control channel
    input  wire logic       cc_xfer_done_i,
    input  wire logic       cc_contention_i,
    output logic            fwd_cc_enable_o,
    output logic            rev_cc_enable_o,
    output logic            ack_frame_o,
    // Open-drain pins
    output logic            err_out_o,
    output logic            err_oe_n_o,
    input  wire logic [1:0] gpio_in_i,
    output logic      [1:0] gpio_out_o,
    output logic      [1:0] gpio_oe_n_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dlem_lock_e  lock_state;
    dlem_lock_e  next_lock_state;
    logic [7:0]  link_ctrl;
    logic [7:0]  filter_ctrl;
    logic [7:0]  gpio_ctrl;
    logic [7:0]  sel_ctrl;
    logic        config_write_lock;
    logic        crypt_enable;
    logic        auth_begun_flag;
    logic [7:0]  err_threshold;
    logic [7:0]  decode_error_count;
    logic [7:0]  pattern_error_count;
    logic [3:0]  win_sym;
    logic [2:0]  win_err;
    logic        err_asserted;
    logic [4:0]  auto_timer;
    logic [13:0] blackout_cnt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        wr_ok            = reg_wr_i && !(config_write_lock && reg_addr_i <= ADDR_LOCK_LAST);
    wire        wr_link          = wr_ok && reg_addr_i == ADDR_LINK_CTRL;
    wire        wr_filter        = wr_ok && reg_addr_i == ADDR_FILTER_CTRL;
    wire        wr_gpio          = wr_ok && reg_addr_i == ADDR_GPIO_CTRL;
    wire        wr_lock          = wr_ok && reg_addr_i == ADDR_LOCK_CTRL;
    wire        wr_crypt         = wr_ok && reg_addr_i == ADDR_CRYPT_CTRL;
    wire        wr_thresh        = wr_ok && reg_addr_i == ADDR_ERR_THRESH;
    wire        rd_decode        = reg_rd_i && reg_addr_i == ADDR_DECODE_ERR;
    wire        rd_pattern       = reg_rd_i && reg_addr_i == ADDR_PATTERN_ERR;

    wire        pattern_mode     = link_ctrl[BIT_PATTERN_EN];
    wire        auto_clear_en    = gpio_ctrl[BIT_AUTO_CLEAR];
    wire        is_locked        = lock_state == DLEM_LOCKED;

    // Errors only count while locked; losing lock freezes the counter
    wire        count_err        = is_locked && symbol_valid_i && decode_err_i && !pattern_mode;
    wire [2:0]  win_err_inc      = win_err + 3'(count_err);
    wire        rate_loss        = count_err && win_err_inc >= WIN_LOSS_ERRS;
    wire        count_pat        = pattern_mode && pattern_err_i;

    wire        auto_fire        = auto_clear_en && !pattern_mode && err_asserted
                                   && auto_timer == 5'(AUTO_CLEAR_CYC - 1);
    wire        lock_gain        = !is_locked && video_lock_acq_i;
    wire        decode_clear     = lock_gain || rd_decode || auto_fire;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    logic [7:0] next_decode_count;
    logic [7:0] next_pattern_count;
    logic       next_err_asserted;

    always_comb begin
        if (pattern_mode) begin
            next_decode_count = 8'h00;
        end else if (decode_clear) begin
            // An error in the clearing cycle survives the clear
            next_decode_count = count_err ? 8'h01 : 8'h00;
        end else if (count_err && decode_error_count != COUNT_MAX) begin
            next_decode_count = decode_error_count + 8'h01;
        end else begin
            next_decode_count = decode_error_count;
        end
    end

    always_comb begin
        if (rd_pattern) begin
            next_pattern_count = count_pat ? 8'h01 : 8'h00;
        end else if (count_pat && pattern_error_count != COUNT_MAX) begin
            next_pattern_count = pattern_error_count + 8'h01;
        end else begin
            next_pattern_count = pattern_error_count;
        end
    end

    // Pin is sticky: threshold crossing sets, counter clear releases
    wire err_set = pattern_mode ? (next_pattern_count != 8'h00)
                                : (next_decode_count > err_threshold);
    always_comb begin
        if (err_set) begin
            next_err_asserted = 1'b1;
        end else if (decode_clear || (pattern_mode && rd_pattern)) begin
            next_err_asserted = 1'b0;
        end else begin
            next_err_asserted = err_asserted;
        end
    end

    always_comb begin
        case (lock_state)
            DLEM_UNLOCKED: next_lock_state = video_lock_acq_i ? DLEM_LOCKED : DLEM_UNLOCKED;
            DLEM_LOCKED:   next_lock_state = rate_loss ? DLEM_RELOCK : DLEM_LOCKED;
            DLEM_RELOCK:   next_lock_state = video_lock_acq_i ? DLEM_LOCKED : DLEM_RELOCK;
            default:       next_lock_state = DLEM_UNLOCKED;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            link_ctrl         <= RST_LINK_CTRL;
            filter_ctrl       <= 8'h00;
            gpio_ctrl         <= RST_GPIO_CTRL;
            sel_ctrl          <= 8'h00;
            config_write_lock <= 1'b0;
            crypt_enable      <= 1'b0;
            err_threshold     <= RST_ERR_THRESH;
        end else if (ce_i) begin
            if (wr_link)   link_ctrl     <= reg_wdata_i;
            if (wr_filter) filter_ctrl   <= reg_wdata_i;
            if (wr_gpio)   gpio_ctrl     <= reg_wdata_i;
            if (wr_lock)   sel_ctrl      <= reg_wdata_i;
            if (wr_thresh) err_threshold <= reg_wdata_i;
            if (wr_crypt)  crypt_enable  <= reg_wdata_i[BIT_CRYPT_EN];
            if (wr_lock && reg_wdata_i[BIT_CFG_LOCK]) begin
                config_write_lock <= 1'b1;
            end
        end
    end

    // Key vector write sets the flag, winning over a software clear
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            auth_begun_flag <= 1'b0;
        end else if (ce_i) begin
            if (key_vector_written_i) begin
                auth_begun_flag <= 1'b1;
            end else if (wr_crypt) begin
                auth_begun_flag <= reg_wdata_i[BIT_AUTH_BEGUN];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            lock_state          <= DLEM_UNLOCKED;
            decode_error_count  <= 8'h00;
            pattern_error_count <= 8'h00;
            err_asserted        <= 1'b0;
        end else if (ce_i) begin
            lock_state          <= next_lock_state;
            decode_error_count  <= next_decode_count;
            pattern_error_count <= next_pattern_count;
            err_asserted        <= next_err_asserted;
        end
    end

    // Rate window restarts on every lock change
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            win_sym <= 4'h0;
            win_err <= 3'h0;
        end else if (ce_i) begin
            if (!is_locked || rate_loss || (symbol_valid_i && win_sym == WIN_LAST)) begin
                win_sym <= 4'h0;
                win_err <= 3'h0;
            end else if (symbol_valid_i) begin
                win_sym <= win_sym + 4'h1;
                win_err <= win_err_inc;
            end
        end
    end

    // Auto clear delay counted from pin assertion
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            auto_timer <= 5'h00;
        end else if (ce_i) begin
            if (!err_asserted || !auto_clear_en || pattern_mode || auto_fire) begin
                auto_timer <= 5'h00;
            end else begin
                auto_timer <= auto_timer + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            blackout_cnt <= 14'h0000;
        end else if (ce_i) begin
            if (link_start_stop_i) begin
                blackout_cnt <= 14'(REV_BLACKOUT_CYCLES);
            end else if (blackout_cnt != 14'h0000) begin
                blackout_cnt <= blackout_cnt - 14'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            ADDR_LINK_CTRL:   rd_mux = link_ctrl;
            ADDR_FILTER_CTRL: rd_mux = filter_ctrl;
            ADDR_GPIO_CTRL:   rd_mux = {gpio_ctrl[7:4], gpio_ctrl[BIT_GPIO1_OUT], gpio_in_i[1],
                                        gpio_ctrl[BIT_GPIO0_OUT], gpio_in_i[0]};
            ADDR_LOCK_CTRL:   rd_mux = {sel_ctrl[7:1], config_write_lock};
            ADDR_CRYPT_CTRL:  rd_mux = {6'h00, auth_begun_flag, crypt_enable};
            ADDR_DECODE_ERR:  rd_mux = decode_error_count;
            ADDR_PATTERN_ERR: rd_mux = pattern_error_count;
            ADDR_ERR_THRESH:  rd_mux = err_threshold;
            default:          rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    wire gpio1_level = sel_ctrl[BIT_GPIO1_SEL] ? auth_begun_flag : gpio_ctrl[BIT_GPIO1_OUT];
    wire gpio0_level = sel_ctrl[BIT_GPIO0_SEL] ? crypt_enable : gpio_ctrl[BIT_GPIO0_OUT];
    wire cc_open     = link_ctrl[BIT_FWD_CC] || link_ctrl[BIT_REV_CC];

    assign lock_o                = is_locked && !config_link_i;
    assign relock_req_o          = lock_state == DLEM_RELOCK;
    assign pattern_test_active_o = pattern_mode;
    assign filter_bypass_o       = filter_ctrl[2:0];
    assign fwd_cc_enable_o       = link_ctrl[BIT_FWD_CC];
    assign rev_cc_enable_o       = link_ctrl[BIT_REV_CC] && blackout_cnt == 14'h0000;
    assign ack_frame_o           = cc_xfer_done_i && !cc_contention_i && cc_open;
    assign err_out_o             = 1'b0;
    assign err_oe_n_o            = !err_asserted;
    assign gpio_out_o            = 2'b00;
    assign gpio_oe_n_o           = {gpio1_level, gpio0_level};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_count_saturates: assert property (
        ce_i && decode_error_count == COUNT_MAX && !decode_clear && !pattern_mode
        |=> decode_error_count == COUNT_MAX)
        else $error("decode counter left its saturated value");

    chk_read_clears_count: assert property (
        ce_i && rd_decode && !count_err && !pattern_mode |=> decode_error_count == 8'h00)
        else $error("decode counter not cleared by read");

    chk_pattern_holds_zero: assert property (
        ce_i && pattern_mode |=> decode_error_count == 8'h00)
        else $error("decode counter nonzero in pattern test");

    chk_rate_drops_lock: assert property (
        ce_i && rate_loss |=> lock_state == DLEM_RELOCK && !lock_o)
        else $error("lock kept at high error rate");

    chk_frozen_unlocked: assert property (
        ce_i && !is_locked && !decode_clear && !pattern_mode |=> $stable(decode_error_count))
        else $error("counter moved while unlocked");

    chk_pattern_err_pin: assert property (
        ce_i && pattern_mode && pattern_err_i |=> !err_oe_n_o)
        else $error("pin not driven on pattern error");

    chk_auto_clear_time: assert property (
        auto_timer <= 5'(AUTO_CLEAR_CYC - 1))
        else $error("auto clear timer ran past the release point");

    chk_auto_release: assert property (
        $rose(err_asserted) && auto_clear_en && !pattern_mode
        && !count_err ##1 (ce_i && auto_clear_en && !pattern_mode && !count_err) [*8]
        ##1 (ce_i && auto_clear_en && !pattern_mode && !count_err) [*8]
        ##1 (ce_i && auto_clear_en && !pattern_mode && !count_err) [*4]
        |-> !err_asserted)
        else $error("auto clear did not release the pin in time");

    chk_no_auto_in_test: assert property (
        ce_i && pattern_mode && err_asserted && !rd_pattern && !rd_decode && !lock_gain
        |=> err_asserted)
        else $error("auto clear released the pin in pattern test");

    chk_lock_write_block: assert property (
        ce_i && config_write_lock && reg_wr_i |=> $stable(link_ctrl) && $stable(gpio_ctrl))
        else $error("locked register changed");

    chk_blackout_rev: assert property (
        ce_i && link_start_stop_i |=> !rev_cc_enable_o [*8])
        else $error("reverse channel open during blackout");

    chk_no_ack_contend: assert property (
        cc_contention_i |-> !ack_frame_o)
        else $error("acknowledge on contended transfer");

    chk_auth_gpio1: assert property (
        ce_i && key_vector_written_i && sel_ctrl[BIT_GPIO1_SEL] |=> auth_begun_flag && gpio_oe_n_o[1])
        else $error("auth flag or pin not raised");

    chk_config_no_lock: assert property (
        config_link_i |-> !lock_o)
        else $error("lock shown on configuration link");

    cov_rate_loss:   cover property (ce_i && rate_loss);
    cov_auto_clear:  cover property (ce_i && auto_fire);
    cov_pattern_err: cover property (ce_i && count_pat && !err_asserted);
    cov_lock_regain: cover property (lock_state == DLEM_RELOCK ##[1:50] lock_state == DLEM_LOCKED);

endmodule : dlem_monitor

`default_nettype wire

// *** verification/dlem_far_end.sv ***
// Far-end serializer model: symbol stream with injected errors
`timescale 1ns/1ns
`default_nettype none
module dlem_far_end (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Stream control
    input  wire logic       en_i,
    input  wire logic       pattern_i,
    input  wire logic [7:0] err_period_i,
    // Link events
    output logic            symbol_valid_o,
    output logic            decode_err_o,
    output logic            pattern_err_o
);
    logic [7:0] idx;
    logic       hit;
    assign hit = en_i && (err_period_i != 8'h00) && (idx == err_period_i - 8'h01);
    initial begin
        {symbol_valid_o, decode_err_o, pattern_err_o} = 3'b000;
        idx = 8'h00;
    end
    // Launched on the falling edge, away from the sampling edge
    always @(negedge clk_i) begin
        idx            <= (!rst_n_i || !en_i || hit) ? 8'h00 : idx + 8'h01;
        symbol_valid_o <= en_i;
        decode_err_o   <= hit;
        pattern_err_o  <= hit && pattern_i;
    end
endmodule : dlem_far_end
`default_nettype wire

// *** verification/deser_link_error_monitor_test.sv ***
// Self-checking bench for the link error monitor
`timescale 1ns/1ns
`default_nettype none
module deser_link_error_monitor_test;
    import dlem_pkg::*;
    localparam int BLACK = 40;
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, vl = 1'b0, cfg = 1'b0;
    logic       lss = 1'b0, kv = 1'b0, done = 1'b0, cont = 1'b0, en = 1'b0, pat = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, per = 8'h00, rdata;
    logic       rvalid, sv, de, pe, lock, relock, pta, fwd, rev, ack, eo, eoe_n;
    logic [2:0] fb;
    logic [1:0] go, goe_n;
    int         errors = 0, check_count = 0, n;
    logic [24:0] rows [7] = '{25'h004_0003, 25'h006_000F, 25'h10F_0202,
                              25'h105_0707, 25'h00D_0000, 25'h040_0000, 25'h101_4800};
    always #25 clk = ~clk;
    dlem_monitor #(.REV_BLACKOUT_CYCLES(BLACK)) dut (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .symbol_valid_i(sv), .decode_err_i(de), .pattern_err_i(pe),
        .video_lock_acq_i(vl), .config_link_i(cfg), .link_start_stop_i(lss), .key_vector_written_i(kv),
        .lock_o(lock), .relock_req_o(relock), .pattern_test_active_o(pta), .filter_bypass_o(fb),
        .cc_xfer_done_i(done), .cc_contention_i(cont), .fwd_cc_enable_o(fwd), .rev_cc_enable_o(rev),
        .ack_frame_o(ack), .err_out_o(eo), .err_oe_n_o(eoe_n), .gpio_in_i(goe_n), .gpio_out_o(go),
        .gpio_oe_n_o(goe_n));
    dlem_far_end far (.clk_i(clk), .rst_n_i(rst_n), .en_i(en), .pattern_i(pat), .err_period_i(per),
        .symbol_valid_o(sv), .decode_err_o(de), .pattern_err_o(pe));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wd = d;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk(8'h01, {7'h00, rvalid});
        chk(e, rdata);
        @(negedge clk);
    endtask : rd_reg
    // Model sees control one falling edge late, so cnt symbols go out
    task automatic stream(input int cnt, input logic [7:0] p);
        per <= p;
        en <= 1'b1;
        repeat (cnt) @(negedge clk);
        en <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : stream
    task automatic video_lock;
        vl = 1'b1;
        @(negedge clk);
        vl = 1'b0;
        @(negedge clk);
    endtask : video_lock
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(8'h13, {3'h0, eoe_n, 2'h0, goe_n});
        chk(8'h00, {5'h00, eo, go});
        foreach (rows[i]) begin
            if (rows[i][24]) wr_reg(rows[i][23:16], rows[i][15:8]);
            rd_reg(rows[i][23:16], rows[i][7:0]);
        end
        chk(8'h07, {5'h00, fb});
        $display("register table done");
        video_lock();
        stream(15, 8'h05);
        chk(8'h01, {7'h00, lock});
        chk(8'h00, {7'h00, eoe_n});
        rd_reg(ADDR_DECODE_ERR, 8'h03);
        chk(8'h01, {7'h00, eoe_n});
        cfg = 1'b1;
        #1 chk(8'h00, {7'h00, lock});
        cfg = 1'b0;
        stream(1800, 8'h06);
        rd_reg(ADDR_DECODE_ERR, COUNT_MAX);
        wr_reg(ADDR_ERR_THRESH, 8'h01);
        stream(4, 8'h01);
        chk(8'h02, {5'h00, eoe_n, relock, lock});
        video_lock();
        chk(8'h03, {6'h00, eoe_n, lock});
        rd_reg(ADDR_DECODE_ERR, 8'h00);
        $display("counting done");
        wr_reg(ADDR_ERR_THRESH, 8'h00);
        wr_reg(ADDR_GPIO_CTRL, 8'h2A);
        per <= 8'h01;
        en  <= 1'b1;
        @(negedge clk);
        en  <= 1'b0;
        n = 0;
        while (eoe_n === 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (eoe_n === 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(8'(AUTO_CLEAR_CYC), 8'(n));
        pat <= 1'b1;
        wr_reg(ADDR_LINK_CTRL, 8'h23);
        chk(8'h01, {7'h00, pta});
        stream(3, 8'h03);
        repeat (40) @(negedge clk);
        chk(8'h00, {7'h00, eoe_n});
        rd_reg(ADDR_PATTERN_ERR, 8'h01);
        chk(8'h01, {7'h00, eoe_n});
        rd_reg(ADDR_DECODE_ERR, 8'h00);
        wr_reg(ADDR_LINK_CTRL, 8'h03);
        pat <= 1'b0;
        $display("auto clear and pattern done");
        repeat (100) @(negedge clk);
        lss = 1'b1;
        @(negedge clk);
        lss = 1'b0;
        n = 0;
        while (rev === 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(8'(BLACK), 8'(n));
        done = 1'b1;
        cont = 1'b1;
        #1 chk(8'h00, {7'h00, ack});
        cont = 1'b0;
        #1 chk(8'h01, {7'h00, ack});
        wr_reg(ADDR_LINK_CTRL, 8'h00);
        chk(8'h00, {5'h00, fwd, rev, ack});
        done = 1'b0;
        wr_reg(ADDR_LINK_CTRL, 8'h03);
        $display("control channel done");
        wr_reg(ADDR_LOCK_CTRL, 8'h06);
        kv = 1'b1;
        @(negedge clk);
        kv = 1'b0;
        rd_reg(ADDR_CRYPT_CTRL, 8'h02);
        chk(8'h02, {6'h00, goe_n});
        wr_reg(ADDR_CRYPT_CTRL, 8'h01);
        chk(8'h01, {6'h00, goe_n});
        wr_reg(ADDR_LOCK_CTRL, 8'h07);
        wr_reg(ADDR_ERR_THRESH, 8'h55);
        rd_reg(ADDR_ERR_THRESH, 8'h00);
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        wr_reg(ADDR_ERR_THRESH, 8'h55);
        rd_reg(ADDR_ERR_THRESH, 8'h55);
        $display("auth and lock done");
        summarize();
    end
endmodule : deser_link_error_monitor_test
`default_nettype wire
